// >>> cmp_digital_pkg.sv
// Purpose: Shared constants and types for the comparator digital interface
// Assumes: 8-bit register port with a 4-bit address
// Notes: Two identical comparator channels
package cmp_digital_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CMP = 2;
  // Register addresses, channel base plus offset, then shared registers at fixed addresses
  localparam logic [3:0] CMP_A_BASE = 4'h0;
  localparam logic [3:0] CMP_B_BASE = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h1;
  localparam logic [3:0] OFS_MUX = 4'h2;
  localparam logic [3:0] IRQ_SRC_ADDR = 4'h8;
  localparam logic [3:0] EVT_STAT_ADDR = 4'h9;
  localparam logic [3:0] EVT_MASK_ADDR = 4'hA;
  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  // Mode register fields
  localparam int MODE_RSVD_BIT = 7;
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_RESP_LSB = 0;
  // Input select register fields
  localparam int MUX_POS_LSB = 0;
  localparam int MUX_NEG_LSB = 4;
  // Reset values
  localparam logic [1:0] RESP_RST = 2'h2;
  localparam logic [1:0] HYST_RST = 2'h0;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] EVT_RST = 4'h0;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic enable;
    logic [1:0] hyst_pos;
    logic [1:0] hyst_neg;
    logic [1:0] resp_mode;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
  } cmp_cfg_t;

  typedef struct packed {
    logic en;
    logic [1:0] hyp;
    logic [1:0] hyn;
    logic rise_flag;
    logic fall_flag;
    logic rise_ie;
    logic fall_ie;
    logic [1:0] resp;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
  } cmp_state_t;

  localparam cmp_state_t CMP_STATE_RST = '{1'b0, HYST_RST, HYST_RST, 1'b0, 1'b0,
                                           1'b0, 1'b0, RESP_RST, SEL_RST, SEL_RST};
endpackage

// >>> cmp_digital_if.sv
// Purpose: Digital side of two voltage comparators
// Assumes: i_cmp_decide comes from the analog cores, asynchronous
// Notes: Raw outputs are combinational so they survive a stopped clock
//
// Behaviour
// - Enabled output is pos>neg, disabled forces zero
// - Synchronised latched output readable, interrupting, routable
// - Raw unclocked output valid without clock
// - Raw output feeds wake and reset logic
// - Separate rising and falling edge flags
// - Edges set flags regardless of enables
// - Flags stay set until software clears
// - Rising and falling interrupts enabled separately
// - Comparator interrupts need edge, source, global enables
// - Two-bit response time mode, four settings
// - Disabled comparator goes to shutdown
// - Both channels identical except wake/reset use
// - Software selects positive and negative inputs
// - Enable bit set to use, clear to shutdown
// - Control: enable, output, rise, fall bits
// - Mode: rise/fall enables, mode, bit7 one
`timescale 1ns/1ps
`default_nettype none
module cmp_digital_if
  import cmp_digital_pkg::*;
(
  input wire logic i_mclk, // System clock, 200 MHz
  input wire logic i_rst, // Async reset, active high
  input wire reg_req_t i_bus, // Register port request
  output logic [7:0] o_rdata, // Read data, cycle after read strobe
  input wire logic [1:0] i_cmp_decide, // Analog decisions, bit0 a, bit1 b
  input wire logic i_global_irq_en, // CPU global interrupt enable
  output cmp_cfg_t o_cmp_a_cfg, // Analog settings, channel a
  output cmp_cfg_t o_cmp_b_cfg, // Analog settings, channel b
  output logic o_cmp_a_latched_out, // Synchronised output a
  output logic o_cmp_b_latched_out, // Synchronised output b
  output logic o_cmp_a_raw_out, // Unclocked output a
  output logic o_cmp_b_raw_out, // Unclocked output b
  output logic o_cmp_a_irq, // Comparator a interrupt request
  output logic o_cmp_b_irq, // Comparator b interrupt request
  output logic o_irq // Masked event status interrupt
);

  function automatic logic [3:0] cmp_base(input int idx);
    cmp_base = (idx == 0) ? CMP_A_BASE : CMP_B_BASE;
  endfunction

  function automatic logic bus_hit(input reg_req_t req, input logic [3:0] addr);
    bus_hit = (req.addr == addr);
  endfunction

  cmp_state_t st_reg [NUM_CMP];
  cmp_state_t st_next [NUM_CMP];
  logic [NUM_CMP-1:0] raw_w;
  logic [NUM_CMP-1:0] sync1_reg;
  logic [NUM_CMP-1:0] sync2_reg;
  logic [NUM_CMP-1:0] prev_reg;
  logic [NUM_CMP-1:0] rise_evt;
  logic [NUM_CMP-1:0] fall_evt;
  logic [NUM_CMP-1:0] cmp_irq_reg;
  logic [NUM_CMP-1:0] cmp_irq_next;
  logic [1:0] src_en_reg;
  logic [1:0] src_en_next;
  logic [3:0] evt_stat_reg;
  logic [3:0] evt_stat_next;
  logic [3:0] evt_mask_reg;
  logic [3:0] evt_mask_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] evt_set;

  // One clock domain, so every check below shares this clock and reset
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      // Gating before the synchroniser keeps the raw path clock free
      assign raw_w[g] = i_cmp_decide[g] & st_reg[g].en;
      assign rise_evt[g] = sync2_reg[g] & ~prev_reg[g];
      assign fall_evt[g] = ~sync2_reg[g] & prev_reg[g];

      always_comb begin
        st_next[g] = st_reg[g];
        if (i_bus.wr && bus_hit(i_bus, cmp_base(g) + OFS_CTRL)) begin
          st_next[g].en = i_bus.wdata[CTRL_EN_BIT];
          st_next[g].rise_flag = i_bus.wdata[CTRL_RISE_BIT];
          st_next[g].fall_flag = i_bus.wdata[CTRL_FALL_BIT];
          st_next[g].hyp = i_bus.wdata[CTRL_HYP_LSB +: 2];
          st_next[g].hyn = i_bus.wdata[CTRL_HYN_LSB +: 2];
        end
        if (i_bus.wr && bus_hit(i_bus, cmp_base(g) + OFS_MODE)) begin
          st_next[g].rise_ie = i_bus.wdata[MODE_RIE_BIT];
          st_next[g].fall_ie = i_bus.wdata[MODE_FIE_BIT];
          st_next[g].resp = i_bus.wdata[MODE_RESP_LSB +: 2];
        end
        if (i_bus.wr && bus_hit(i_bus, cmp_base(g) + OFS_MUX)) begin
          st_next[g].pos_sel = i_bus.wdata[MUX_POS_LSB +: 4];
          st_next[g].neg_sel = i_bus.wdata[MUX_NEG_LSB +: 4];
        end
        // Hardware set wins over a software clear in the same cycle
        if (rise_evt[g]) begin
          st_next[g].rise_flag = 1'b1;
        end
        if (fall_evt[g]) begin
          st_next[g].fall_flag = 1'b1;
        end
        cmp_irq_next[g] = ((st_next[g].rise_flag & st_next[g].rise_ie) |
                           (st_next[g].fall_flag & st_next[g].fall_ie)) &
                          src_en_next[g] & i_global_irq_en;
      end

      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          st_reg[g] <= CMP_STATE_RST;
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
          cmp_irq_reg[g] <= 1'b0;
        end else begin
          st_reg[g] <= st_next[g];
          sync1_reg[g] <= raw_w[g];
          sync2_reg[g] <= sync1_reg[g];
          prev_reg[g] <= sync2_reg[g];
          cmp_irq_reg[g] <= cmp_irq_next[g];
        end
      end

      assign evt_set[2*g] = rise_evt[g];
      assign evt_set[2*g+1] = fall_evt[g];

      // Checks
      property p_disabled_zero;
        !st_reg[g].en |-> !raw_w[g];
      endproperty
      a_disabled_zero: assert property (p_disabled_zero)
        else $error("raw output high while disabled");

      property p_sync_delay;
        $rose(raw_w[g]) |-> ##2 sync2_reg[g];
      endproperty
      a_sync_delay: assert property (p_sync_delay)
        else $error("latched output missed a rise");

      property p_rise_sets;
        rise_evt[g] |=> st_reg[g].rise_flag;
      endproperty
      a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge did not set flag");

      property p_fall_sets;
        fall_evt[g] |=> st_reg[g].fall_flag;
      endproperty
      a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge did not set flag");

      property p_sticky;
        st_reg[g].rise_flag && !(i_bus.wr && i_bus.addr == cmp_base(g)) |=> st_reg[g].rise_flag;
      endproperty
      a_sticky: assert property (p_sticky)
        else $error("rise flag dropped without software");

      property p_fall_sticky;
        st_reg[g].fall_flag && !(i_bus.wr && i_bus.addr == cmp_base(g)) |=> st_reg[g].fall_flag;
      endproperty
      a_fall_sticky: assert property (p_fall_sticky)
        else $error("fall flag dropped without software");

      property p_status_set;
        rise_evt[g] |=> evt_stat_reg[2*g];
      endproperty
      a_status_set: assert property (p_status_set)
        else $error("rising edge missed the event status");

      property p_resp_write;
        i_bus.wr && i_bus.addr == cmp_base(g) + OFS_MODE |=> st_reg[g].resp == $past(i_bus.wdata[1:0]);
      endproperty
      a_resp_write: assert property (p_resp_write)
        else $error("response mode not taken from write");

      property p_sel_write;
        i_bus.wr && i_bus.addr == cmp_base(g) + OFS_MUX |=>
          {st_reg[g].neg_sel, st_reg[g].pos_sel} == $past(i_bus.wdata);
      endproperty
      a_sel_write: assert property (p_sel_write)
        else $error("input select not taken from write");

      property p_irq_gate;
        cmp_irq_reg[g] |-> $past(i_global_irq_en) && src_en_reg[g];
      endproperty
      a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without source or global enable");

      property p_irq_cause;
        cmp_irq_reg[g] |-> (st_reg[g].rise_flag && st_reg[g].rise_ie) ||
                           (st_reg[g].fall_flag && st_reg[g].fall_ie);
      endproperty
      a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled flag");

      property p_shutdown;
        i_bus.wr && i_bus.addr == cmp_base(g) && !i_bus.wdata[CTRL_EN_BIT] |=> !st_reg[g].en ##2 !sync2_reg[g];
      endproperty
      a_shutdown: assert property (p_shutdown)
        else $error("disable did not shut down");

      property p_single_event;
        rise_evt[g] |=> !rise_evt[g];
      endproperty
      a_single_event: assert property (p_single_event)
        else $error("one transition gave two events");

      c_rise: cover property (rise_evt[g] && st_reg[g].en);
      c_fall: cover property (fall_evt[g] && st_reg[g].en);
      c_irq: cover property ($rose(cmp_irq_reg[g]));
    end
  endgenerate

  always_comb begin
    src_en_next = src_en_reg;
    evt_mask_next = evt_mask_reg;
    evt_stat_next = evt_stat_reg;
    rdata_next = RDATA_RST;
    if (i_bus.wr && bus_hit(i_bus, IRQ_SRC_ADDR)) begin
      src_en_next = i_bus.wdata[1:0];
    end
    if (i_bus.wr && bus_hit(i_bus, EVT_MASK_ADDR)) begin
      evt_mask_next = i_bus.wdata[3:0];
    end
    if (i_bus.rd && bus_hit(i_bus, EVT_STAT_ADDR)) begin
      evt_stat_next = EVT_RST;
    end
    evt_stat_next = evt_stat_next | evt_set;
    irq_next = |(evt_stat_next & evt_mask_next);
    if (i_bus.rd) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (bus_hit(i_bus, cmp_base(i) + OFS_CTRL)) begin
          rdata_next = {st_reg[i].en, sync2_reg[i], st_reg[i].rise_flag, st_reg[i].fall_flag,
                        st_reg[i].hyp, st_reg[i].hyn};
        end
        if (bus_hit(i_bus, cmp_base(i) + OFS_MODE)) begin
          rdata_next = {1'b1, 1'b0, st_reg[i].rise_ie, st_reg[i].fall_ie,
                        2'h0, st_reg[i].resp};
        end
        if (bus_hit(i_bus, cmp_base(i) + OFS_MUX)) begin
          rdata_next = {st_reg[i].neg_sel, st_reg[i].pos_sel};
        end
      end
      if (bus_hit(i_bus, IRQ_SRC_ADDR)) begin
        rdata_next = {6'h00, src_en_reg};
      end
      if (bus_hit(i_bus, EVT_STAT_ADDR)) begin
        rdata_next = {4'h0, evt_stat_reg};
      end
      if (bus_hit(i_bus, EVT_MASK_ADDR)) begin
        rdata_next = {4'h0, evt_mask_reg};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      src_en_reg <= SRC_RST;
      evt_mask_reg <= EVT_RST;
      evt_stat_reg <= EVT_RST;
      irq_reg <= 1'b0;
      rdata_reg <= RDATA_RST;
    end else begin
      src_en_reg <= src_en_next;
      evt_mask_reg <= evt_mask_next;
      evt_stat_reg <= evt_stat_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  property p_mode_bit7;
    i_bus.rd && (i_bus.addr == CMP_A_BASE + OFS_MODE) |=> o_rdata[MODE_RSVD_BIT];
  endproperty
  a_mode_bit7: assert property (p_mode_bit7)
    else $error("mode bit 7 did not read one");

  property p_out_bit;
    i_bus.rd && (i_bus.addr == CMP_A_BASE) |=> o_rdata[CTRL_OUT_BIT] == $past(sync2_reg[0]);
  endproperty
  a_out_bit: assert property (p_out_bit)
    else $error("output bit does not show latched state");

  c_stat_irq: cover property ($rose(irq_reg));

  // Raw outputs are deliberately unclocked; everything else is a flop
  assign o_cmp_a_raw_out = raw_w[0];
  assign o_cmp_b_raw_out = raw_w[1];
  assign o_cmp_a_latched_out = sync2_reg[0];
  assign o_cmp_b_latched_out = sync2_reg[1];
  assign o_cmp_a_cfg = '{st_reg[0].en, st_reg[0].hyp, st_reg[0].hyn, st_reg[0].resp,
                         st_reg[0].pos_sel, st_reg[0].neg_sel};
  assign o_cmp_b_cfg = '{st_reg[1].en, st_reg[1].hyp, st_reg[1].hyn, st_reg[1].resp,
                         st_reg[1].pos_sel, st_reg[1].neg_sel};
  assign o_cmp_a_irq = cmp_irq_reg[0];
  assign o_cmp_b_irq = cmp_irq_reg[1];
  assign o_irq = irq_reg;
  assign o_rdata = rdata_reg;

endmodule // cmp_digital_if
`default_nettype wire

// >>> cmp_front_model.sv
// Purpose: Analog core stand-in for both comparator channels
// Assumes: Pin levels are unsigned codes chosen by the bench
// Notes: A shut-down core gives no valid decision
`timescale 1ns/1ps
`default_nettype none
module cmp_front_model
  import cmp_digital_pkg::*;
(
  input wire logic i_mclk, // System clock
  input wire cmp_cfg_t i_cfg_a, // Settings, channel a
  input wire cmp_cfg_t i_cfg_b, // Settings, channel b
  input wire logic [15:0][7:0] i_pins, // Pin levels
  output logic [1:0] o_decide // Decisions, bit0 a, bit1 b
);
  logic idle_reg = 1'b0;
  always @(posedge i_mclk) begin
    idle_reg <= ~idle_reg;
  end
  // Toggles while shut down, so a decision leaking past the enable is seen
  always_comb begin
    o_decide[0] = i_cfg_a.enable ? (i_pins[i_cfg_a.pos_sel] > i_pins[i_cfg_a.neg_sel]) : idle_reg;
    o_decide[1] = i_cfg_b.enable ? (i_pins[i_cfg_b.pos_sel] > i_pins[i_cfg_b.neg_sel]) : idle_reg;
  end
endmodule // cmp_front_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the comparator digital interface
// Assumes: cmp_front_model stands in for the analog cores
// Notes: Input selects and pin levels are random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cmp_digital_pkg::*;
;
  logic i_mclk, i_rst, gie, lat_a, lat_b, raw_a, raw_b, irq_a, irq_b, irq;
  reg_req_t bus;
  logic [7:0] rdata;
  logic [1:0] dec;
  cmp_cfg_t cfg_a, cfg_b;
  logic [15:0][7:0] vv;
  int errors, checks_done, cycles, seed;

  cmp_digital_if dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_cmp_decide(dec), .i_global_irq_en(gie), .o_cmp_a_cfg(cfg_a), .o_cmp_b_cfg(cfg_b),
    .o_cmp_a_latched_out(lat_a), .o_cmp_b_latched_out(lat_b), .o_cmp_a_raw_out(raw_a),
    .o_cmp_b_raw_out(raw_b), .o_cmp_a_irq(irq_a), .o_cmp_b_irq(irq_b), .o_irq(irq));
  cmp_front_model far (.i_mclk(i_mclk), .i_cfg_a(cfg_a), .i_cfg_b(cfg_b), .i_pins(vv), .o_decide(dec));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    @(negedge i_mclk);
    chk(rdata, e);
  endtask

  function automatic logic pick(input int ch, input logic a, input logic b);
    return ch ? b : a;
  endfunction

  function automatic logic dec_exp(input logic [3:0] p, input logic [3:0] n);
    return vv[p] > vv[n];
  endfunction

  function automatic logic [7:0] ctl(input logic e, input logic o, input logic r, input logic f);
    return {e, o, r, f, 4'h0};
  endfunction

  task automatic run(input int ch);
    logic [3:0] b, p, n;
    b = ch ? CMP_B_BASE : CMP_A_BASE;
    p = 4'($random(seed));
    n = p + 4'h1 + 4'($unsigned($random(seed)) % 15);
    rd(b + OFS_MODE, 8'h82);
    for (int m = 0; m < 4; m++) begin
      wr(b + OFS_MODE, 8'(m));
      rd(b + OFS_MODE, 8'h80 | 8'(m));
      chk(ch ? cfg_b.resp_mode : cfg_a.resp_mode, 8'(m));
    end
    for (int i = 0; i < 16; i++) vv[i] <= (i == p) ? 8'hC0 : (i == n) ? 8'h40 : 8'($random(seed));
    wr(b + OFS_MUX, {n, p});
    rd(b + OFS_MUX, {n, p});
    cyc(3);
    chk(pick(ch, raw_a, raw_b), 8'h00);
    wr(b + OFS_CTRL, 8'h80);
    cyc(4);
    chk(pick(ch, raw_a, raw_b), dec_exp(p, n));
    chk(pick(ch, lat_a, lat_b), 8'h01);
    rd(b, ctl(1, 1, 1, 0));
    rd(EVT_STAT_ADDR, 8'h01 << (2 * ch));
    rd(EVT_STAT_ADDR, 8'h00);
    rd(b, ctl(1, 1, 1, 0));
    wr(b, 8'h80);
    rd(b, ctl(1, 1, 0, 0));
    wr(b + OFS_MODE, 8'h10);
    wr(IRQ_SRC_ADDR, 8'(1 << ch));
    wr(EVT_MASK_ADDR, 8'h0F);
    gie <= 1'b1;
    vv[p] <= 8'h20;
    cyc(5);
    chk(pick(ch, raw_a, raw_b), 8'h00);
    chk(pick(ch, irq_a, irq_b), 8'h01);
    chk(irq, 8'h01);
    rd(b, ctl(1, 0, 0, 1));
    @(posedge i_mclk);
    gie <= 1'b0;
    cyc(2);
    chk(pick(ch, irq_a, irq_b), 8'h00);
    @(posedge i_mclk);
    gie <= 1'b1;
    wr(b + OFS_MODE, 8'h20);
    cyc(2);
    chk(pick(ch, irq_a, irq_b), 8'h00);
    vv[p] <= 8'hE0;
    cyc(5);
    chk(pick(ch, irq_a, irq_b), 8'h01);
    rd(EVT_STAT_ADDR, 8'h03 << (2 * ch));
    cyc(2);
    chk(irq, 8'h00);
    wr(IRQ_SRC_ADDR, 8'h00);
    cyc(2);
    chk(pick(ch, irq_a, irq_b), 8'h00);
    wr(EVT_MASK_ADDR, 8'h00);
    wr(b, 8'h80);
    wr(b, 8'h00);
    cyc(1);
    chk(pick(ch, raw_a, raw_b), 8'h00);
    chk(ch ? cfg_b.enable : cfg_a.enable, 8'h00);
    cyc(4);
    chk(irq, 8'h00);
    rd(EVT_STAT_ADDR, 8'h02 << (2 * ch));
    wr(b, 8'h00);
    wr(b + OFS_MODE, 8'h02);
    $display("channel %0d pass done", ch);
  endtask

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'h6E31;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    i_rst = 1'b1;
    bus = '0;
    gie = 1'b0;
    vv = '0;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(CMP_A_BASE + OFS_CTRL, 8'h00);
    $display("reset test done");
    for (int it = 0; it < 4; it++) run(it % 2);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
